// File: gpio_input_edge_detector.sv
`default_nettype none

module gpio_input_edge_detector
  import edge_detect_pkg::*;
#(
  parameter int PINS = PIN_COUNT
) (
  input  wire logic        i_clock,
  input  wire logic        i_resetn,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [31:0] i_wb_dat,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [7:0]  i_pins,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  output logic             o_irq,
  output logic      [7:0]  o_pin_dir
);

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic rst_meta_ff;
  logic rst_n_ff;

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [15:0] control_ff;
  logic [15:0] status_ff;
  logic [15:0] mask_ff;
  logic [7:0]  dir_ff;
  logic [7:0]  pin_prev_ff;
  logic [PRIME_CYCLES-1:0] prime_ff;
  logic        ack_ff;
  logic [31:0] rdata_ff;
  logic        irq_ff;
  bus_state_e  bus_ff;

  logic [7:0]  pin_sync;
  logic        bus_req;
  logic [5:0]  reg_idx;
  logic        adr_aligned;
  logic        wr_ctrl;
  logic        wr_dir;
  logic        wr_mask;
  logic        rd_status;
  logic [7:0]  input_pins;
  logic [7:0]  rise_evt;
  logic [7:0]  fall_evt;
  logic [15:0] set_evt;
  logic [15:0] nxt_status;
  logic [15:0] nxt_control;
  logic [15:0] nxt_mask;
  logic [31:0] nxt_rdata;
  logic        primed;

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                             input logic [31:0] wdat,
                                             input logic [3:0]  sel);
    lane_merge = {sel[1] ? wdat[15:8] : old_v[15:8],
                  sel[0] ? wdat[7:0]  : old_v[7:0]};
  endfunction

  // ------------------------------------------------------------
  // Pin synchronisation
  // ------------------------------------------------------------
  // Synchronise pin inputs
  pin_sync #(
    .WIDTH   (PINS)
  ) u_pin_sync (
    .i_clock (i_clock),
    .i_rst_n (rst_n_ff),
    .i_async (i_pins),
    .o_sync  (pin_sync)
  );

  always_ff @(posedge i_clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      pin_prev_ff <= 8'h00;
      prime_ff    <= '0;
    end else begin
      pin_prev_ff <= pin_sync;
      prime_ff    <= {prime_ff[PRIME_CYCLES-2:0], 1'b1};
    end
  end

  assign primed = prime_ff[PRIME_CYCLES-1];

  // ------------------------------------------------------------
  // Edge detection
  // ------------------------------------------------------------
  // Direction zero is input
  assign input_pins = ~dir_ff;
  assign rise_evt   = pin_sync & ~pin_prev_ff & control_ff[RISE_LSB +: PINS] & input_pins & {8{primed}};
  assign fall_evt   = ~pin_sync & pin_prev_ff & control_ff[FALL_LSB +: PINS] & input_pins & {8{primed}};
  assign set_evt    = {rise_evt, fall_evt};

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  assign bus_req     = i_wb_cyc & i_wb_stb & (bus_ff == BUS_IDLE);
  assign reg_idx     = i_wb_adr[7:2];
  assign adr_aligned = (i_wb_adr[1:0] == 2'b00);
  assign wr_ctrl     = bus_req & i_wb_we & adr_aligned & (reg_idx == IDX_CONTROL);
  assign wr_dir      = bus_req & i_wb_we & adr_aligned & (reg_idx == IDX_DIRECTION) & i_wb_sel[0];
  assign wr_mask     = bus_req & i_wb_we & adr_aligned & (reg_idx == IDX_MASK);
  assign rd_status   = bus_req & ~i_wb_we & adr_aligned & (reg_idx == IDX_STATUS);

  assign nxt_control = wr_ctrl ? lane_merge(control_ff, i_wb_dat, i_wb_sel) : control_ff;
  assign nxt_mask    = wr_mask ? lane_merge(mask_ff, i_wb_dat, i_wb_sel) : mask_ff;

  // Sticky flags, set wins over read clear
  assign nxt_status  = (rd_status ? 16'h0000 : status_ff) | set_evt;

  assign nxt_rdata   = !adr_aligned                 ? 32'h0000_0000 :
                       (reg_idx == IDX_CONTROL)     ? {16'h0000, control_ff} :
                       (reg_idx == IDX_STATUS)      ? {16'h0000, status_ff} :
                       (reg_idx == IDX_MASK)        ? {16'h0000, mask_ff} :
                       (reg_idx == IDX_DIRECTION)   ? {24'h000000, dir_ff} :
                       (reg_idx == IDX_PIN_LEVEL)   ? {24'h000000, pin_sync} :
                                                      32'h0000_0000;

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge i_clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      control_ff <= CONTROL_RESET;
      mask_ff    <= MASK_RESET;
      dir_ff     <= DIR_RESET;
      status_ff  <= STATUS_RESET;
    end else begin
      control_ff <= nxt_control;
      mask_ff    <= nxt_mask;
      status_ff  <= nxt_status;
      if (wr_dir) begin
        dir_ff <= i_wb_dat[7:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Bus answer and outputs
  // ------------------------------------------------------------
  always_ff @(posedge i_clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      bus_ff   <= BUS_IDLE;
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      irq_ff   <= 1'b0;
    end else begin
      irq_ff <= |(status_ff & mask_ff);
      case (bus_ff)
        BUS_IDLE: begin
          ack_ff <= bus_req;
          if (bus_req) begin
            rdata_ff <= i_wb_we ? 32'h0000_0000 : nxt_rdata;
            bus_ff   <= BUS_ACK;
          end
        end
        BUS_ACK: begin
          ack_ff <= 1'b0;
          bus_ff <= BUS_IDLE;
        end
        default: begin
          ack_ff <= 1'b0;
          bus_ff <= BUS_IDLE;
        end
      endcase
    end
  end

  assign o_wb_ack  = ack_ff;
  assign o_wb_dat  = rdata_ff;
  assign o_irq     = irq_ff;
  assign o_pin_dir = dir_ff;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!rst_n_ff);

  rise_ctrl_a: assert property (
    wr_ctrl && i_wb_sel[1] |=> control_ff[15:8] == $past(i_wb_dat[15:8]))
    else $error("Rising enable byte not written");

  fall_ctrl_a: assert property (
    wr_ctrl && i_wb_sel[0] |=> control_ff[7:0] == $past(i_wb_dat[7:0]))
    else $error("Falling enable byte not written");

  rise_set_a: assert property (
    (pin_sync & ~pin_prev_ff & control_ff[15:8] & ~dir_ff & {8{primed}}) != 8'h00
    |=> (status_ff[15:8] & $past(rise_evt)) == $past(rise_evt))
    else $error("Rising edge did not set its flag");

  fall_set_a: assert property (
    (~pin_sync & pin_prev_ff & control_ff[7:0] & ~dir_ff & {8{primed}}) != 8'h00
    |=> (status_ff[7:0] & $past(fall_evt)) == $past(fall_evt))
    else $error("Falling edge did not set its flag");

  out_quiet_a: assert property (
    ((status_ff & ~$past(status_ff)) & {$past(dir_ff), $past(dir_ff)}) == 16'h0000)
    else $error("Output pin set an edge flag");

  dir_write_a: assert property (
    wr_dir ##1 (set_evt == 16'h0000) |-> (o_pin_dir == $past(i_wb_dat[7:0]))
    and ((fall_evt & dir_ff) == 8'h00))
    else $error("Direction not applied");

  read_clear_a: assert property (
    rd_status && set_evt == 16'h0000 |=> status_ff == 16'h0000 ##1 o_wb_dat[15:0] == $past(status_ff, 2))
    else $error("Status read did not clear all flags");

  flag_hold_a: assert property (
    !rd_status |=> (status_ff & $past(status_ff)) == $past(status_ff))
    else $error("Flag lost without a read");

  set_wins_a: assert property (
    rd_status && set_evt != 16'h0000 |=> status_ff == $past(set_evt))
    else $error("Edge lost during clearing read");

  sync_path_a: assert property (
    rise_evt != 8'h00 |-> (rise_evt & $past(i_pins, 2) & ~$past(i_pins, 3)) == rise_evt)
    else $error("Edge not taken from synchronised pins");

  irq_level_a: assert property (
    (status_ff & mask_ff) != 16'h0000 |=> o_irq)
    else $error("Interrupt not raised");

  irq_quiet_a: assert property (
    (status_ff & mask_ff) == 16'h0000 |=> !o_irq)
    else $error("Interrupt raised with no unmasked flag");

  ack_pulse_a: assert property (
    o_wb_ack |=> !o_wb_ack)
    else $error("Acknowledge longer than one cycle");

  dir_hold_a: assert property (
    !wr_dir |=> o_pin_dir == $past(o_pin_dir))
    else $error("Direction changed without a write");

endmodule

`default_nettype wire

// File: edge_detect_pkg.sv
// Contract
// - Control bits 15:8 enable rising-edge watch, bit 8+n for pin n.
// - Control bits 7:0 enable falling-edge watch, bit n for pin n.
// - Enabled rising edge on pin n sets status bit 8+n until read.
// - Enabled falling edge on pin n sets status bit n until read.
// - Only pins configured as inputs may set edge flags.
// - Zero flag means no edge since last read; any status read clears all, but an edge in the read cycle still sets its flag.
// - Direction bit n zero means pin n input, one means output.
`default_nettype none

package edge_detect_pkg;

  // ------------------------------------------------------------
  // Register indices, byte address is four times the index
  // ------------------------------------------------------------
  localparam logic [5:0]  IDX_DIRECTION  = 6'h0b;
  localparam logic [5:0]  IDX_PIN_LEVEL  = 6'h0c;
  localparam logic [5:0]  IDX_CONTROL    = 6'h0d;
  localparam logic [5:0]  IDX_STATUS     = 6'h0e;
  localparam logic [5:0]  IDX_MASK       = 6'h10;

  // ------------------------------------------------------------
  // Field layout
  // ------------------------------------------------------------
  localparam int          RISE_LSB       = 8;
  localparam int          FALL_LSB       = 0;
  localparam int          PIN_COUNT      = 8;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [15:0] CONTROL_RESET  = 16'h0000;
  localparam logic [15:0] STATUS_RESET   = 16'h0000;
  localparam logic [15:0] MASK_RESET     = 16'h0000;
  localparam logic [7:0]  DIR_RESET      = 8'h00;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int          SYNC_STAGES    = 2;
  localparam int          PRIME_CYCLES   = 3;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_ACK
  } bus_state_e;

endpackage

`default_nettype wire

// File: pin_sync.sv
`default_nettype none

module pin_sync
  import edge_detect_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  // ------------------------------------------------------------
  // Two-stage synchroniser
  // ------------------------------------------------------------
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;

endmodule

`default_nettype wire

// File: pin_source.sv
`default_nettype none

module pin_source (
  input  wire logic       i_clock,
  input  wire logic [7:0] i_level,
  output logic      [7:0] o_pins
);
  timeunit 1ns;
  timeprecision 1ns;

  always_ff @(posedge i_clock) begin
    o_pins <= i_level;
  end
endmodule

`default_nettype wire

// File: gpio_input_edge_detector_tb.sv
`default_nettype none

`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

module gpio_input_edge_detector_tb;
  import edge_detect_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic        i_clock  = 1'b0;
  logic        resetn   = 1'b0;
  logic        cyc      = 1'b0;
  logic        stb      = 1'b0;
  logic        we       = 1'b0;
  logic [7:0]  adr      = 8'h00;
  logic [7:0]  level    = 8'h00;
  logic [31:0] wdat     = 32'h0;
  logic [3:0]  sel      = 4'hf;
  logic [3:0]  lane     = 4'hf;
  logic [31:0] rdat;
  logic [31:0] rd_q;
  logic [7:0]  pins;
  logic [7:0]  pin_dir;
  logic        ack;
  logic        irq;
  logic [15:0] ctrl, mask, exp_st, r1, r2;
  logic [7:0]  dir, p0, p1;
  logic [7:0]  zero_adr [6] = '{8'h2c, 8'h30, 8'h34, 8'h38, 8'h40, 8'h3c};
  int          bad_count   = 0;
  int          comparisons = 0;
  int          cycles      = 0;
  integer      seed        = 96;

  always #50 i_clock = ~i_clock;

  gpio_input_edge_detector i_dut (
    .i_clock (i_clock), .i_resetn(resetn), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .i_pins(pins), .o_wb_dat(rdat),
    .o_wb_ack(ack), .o_irq(irq), .o_pin_dir(pin_dir)
  );

  pin_source i_src (.i_clock(i_clock), .i_level(level), .o_pins(pins));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge i_clock);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= lane;
    do begin
      @(posedge i_clock);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  function automatic logic [15:0] expect_status(input logic [15:0] c, input logic [7:0] d, a, b);
    return {c[15:8] & ~d & b & ~a, c[7:0] & ~d & a & ~b};
  endfunction

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      bad_count++;
      print_verdict();
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(posedge i_clock);
    resetn <= 1'b1;
    repeat (10) @(posedge i_clock);
    foreach (zero_adr[k]) begin
      wb(1'b0, zero_adr[k], 32'h0, rd_q);
      `CHK("reset value", 32'h0, rd_q)
    end
    wb(1'b1, 8'h38, 32'hffff, rd_q);
    wb(1'b0, 8'h38, 32'h0, rd_q);
    `CHK("status write ignored", 32'h0, rd_q)
    lane = 4'h2;
    wb(1'b1, 8'h34, 32'h5aa5, rd_q);
    lane = 4'h1;
    wb(1'b1, 8'h34, 32'hc33c, rd_q);
    lane = 4'hf;
    wb(1'b0, 8'h34, 32'h0, rd_q);
    `CHK("lane write", 32'h5a3c, rd_q)
    wb(1'b0, 8'h36, 32'h0, rd_q);
    `CHK("misaligned read", 32'h0, rd_q)
    for (int i = 0; i < 40; i++) begin
      ctrl = (i == 0) ? 16'hffff : 16'($random(seed));
      dir  = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
      mask = 16'($random(seed));
      p0   = level;
      p1   = (i < 2) ? ~p0 : 8'($random(seed));
      wb(1'b1, 8'h2c, 32'(dir), rd_q);
      wb(1'b1, 8'h34, 32'(ctrl), rd_q);
      wb(1'b1, 8'h40, 32'(mask), rd_q);
      wb(1'b0, 8'h34, 32'h0, rd_q);
      `CHK("control", 32'(ctrl), rd_q)
      `CHK("direction", dir, pin_dir)
      wb(1'b0, 8'h38, 32'h0, rd_q);
      exp_st = expect_status(ctrl, dir, p0, p1);
      @(posedge i_clock);
      level <= p1;
      repeat (i % 6) @(posedge i_clock);
      wb(1'b0, 8'h38, 32'h0, rd_q);
      r1 = rd_q[15:0];
      repeat (8) @(posedge i_clock);
      `CHK("irq level", (|(exp_st & ~r1 & mask)), irq)
      wb(1'b0, 8'h38, 32'h0, rd_q);
      r2 = rd_q[15:0];
      `CHK("status union", exp_st, r1 | r2)
      `CHK("status overlap", 16'h0, r1 & r2)
      wb(1'b0, 8'h38, 32'h0, rd_q);
      `CHK("status cleared", 32'h0, rd_q)
      wb(1'b0, 8'h30, 32'h0, rd_q);
      `CHK("pin level", 32'(p1), rd_q)
      repeat (2) @(posedge i_clock);
      `CHK("irq cleared", 1'b0, irq)
    end
    print_verdict();
  end
endmodule

`undef CHK

`default_nettype wire
